// ===== timer_capture_pwm_control.sv
// Control, capture overflow and pwm pin direction logic of a timer group.
// Assumes capture events and timer c ticks arrive on clk_i as one-cycle pulses.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
module timer_capture_pwm_control
	import timer_capture_pwm_control_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq_o,
	input wire logic capture_a_event_i,
	input wire logic capture_b_event_i,
	input wire logic timer_c_tick_i,
	input wire logic [15:0] timer_c_count_i,
	input wire logic ext_clock_select_i,
	input wire logic cascade_sixteen_select_i,
	output logic timer_a_count_en_o,
	output logic timer_b_count_en_o,
	output logic timer_ab_16_en_o,
	output logic timer_c_count_en_o,
	output logic timer_c_interrupt_flag_o,
	output logic period_valid_o,
	output logic [15:0] period_o,
	output logic pwm_a_pin_oe_o,
	output logic pwm_b_pin_oe_o,
	output logic pwm_full_resolution_o
);
	// --------------------------------------------------
	// State
	// --------------------------------------------------
	logic [7:0] ctrl_r;
	logic [7:0] port_b_direction_r;
	logic [15:0] cap_a_r;
	logic [15:0] cap_b_r;
	logic unread_a_r;
	logic unread_b_r;
	logic read_a_lo_r;
	logic read_a_hi_r;
	logic read_b_lo_r;
	logic read_b_hi_r;
	logic [4:0] irq_status_r;
	logic [4:0] irq_mask_r;
	logic [7:0] idx;
	logic req;
	logic wr;
	logic rd;
	logic mode_capture;
	logic cap_a_ev;
	logic tick_c;
	logic rd_a_lo;
	logic rd_a_hi;
	logic rd_b_lo;
	logic rd_b_hi;
	logic done_a;
	logic done_b;
	logic [4:0] irq_events;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	// --------------------------------------------------
	// Bus decode
	// --------------------------------------------------
	assign idx = adr_i[9:2];
	assign req = cyc_i && stb_i && !ack_o;
	assign wr = req && we_i && sel_i[0];
	assign rd = req && !we_i;
	assign mode_capture = ctrl_r[BIT_CAP_OR_PERIOD];
	// Capture a exists only in dual capture mode
	assign cap_a_ev = capture_a_event_i && mode_capture;
	assign tick_c = timer_c_tick_i && ctrl_r[BIT_TIMER_C_RUN];
	assign rd_a_lo = rd && hit(idx, IDX_CAP_A_LOW);
	assign rd_a_hi = rd && hit(idx, IDX_CAP_A_HIGH);
	assign rd_b_lo = rd && hit(idx, IDX_CAP_B_LOW);
	assign rd_b_hi = rd && hit(idx, IDX_CAP_B_HIGH);
	// Both bytes, in either order, release the register
	assign done_a = (rd_a_lo || read_a_lo_r) && (rd_a_hi || read_a_hi_r);
	assign done_b = (rd_b_lo || read_b_lo_r) && (rd_b_hi || read_b_hi_r);

	// --------------------------------------------------
	// Bus acknowledge
	// --------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= req;
	end

	// Read data holds until the next read
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (rd)
		begin
			case (idx)
				IDX_CONTROL: dat_o <= {24'h00_0000, ctrl_r};
				IDX_CAP_A_LOW: dat_o <= {24'h00_0000, cap_a_r[7:0]};
				IDX_CAP_A_HIGH: dat_o <= {24'h00_0000, cap_a_r[15:8]};
				IDX_CAP_B_LOW: dat_o <= {24'h00_0000, cap_b_r[7:0]};
				IDX_CAP_B_HIGH: dat_o <= {24'h00_0000, cap_b_r[15:8]};
				IDX_IRQ_STATUS: dat_o <= {27'h000_0000, irq_status_r};
				IDX_IRQ_MASK: dat_o <= {27'h000_0000, irq_mask_r};
				IDX_PORT_B_DIR: dat_o <= {24'h00_0000, port_b_direction_r};
				IDX_STATUS: dat_o <= {30'h0000_0000, unread_b_r, unread_a_r};
				default: dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// --------------------------------------------------
	// Control register
	// --------------------------------------------------
	// One process owns the whole register, flags included
	// Overflow flags: hardware only, read clear wins over a same cycle event
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_r <= CONTROL_RESET;
		else
		begin
			if (wr && hit(idx, IDX_CONTROL))
				ctrl_r[5:0] <= dat_i[5:0];
			if (cap_a_ev && unread_a_r && !done_a)
				ctrl_r[BIT_CAP_A_OVF] <= 1'b1;
			else if (done_a)
				ctrl_r[BIT_CAP_A_OVF] <= 1'b0;
			if (capture_b_event_i && unread_b_r && !done_b)
				ctrl_r[BIT_CAP_B_OVF] <= 1'b1;
			else if (done_b)
				ctrl_r[BIT_CAP_B_OVF] <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			port_b_direction_r <= DIR_RESET;
		else if (wr && hit(idx, IDX_PORT_B_DIR))
			port_b_direction_r <= dat_i[7:0];
	end

	// --------------------------------------------------
	// Capture registers
	// --------------------------------------------------
	// Shared pair: period in mode zero, capture a in mode one
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cap_a_r <= 16'h0000;
		else if (!mode_capture && wr && hit(idx, IDX_CAP_A_LOW))
			cap_a_r[7:0] <= dat_i[7:0];
		else if (!mode_capture && wr && hit(idx, IDX_CAP_A_HIGH))
			cap_a_r[15:8] <= dat_i[7:0];
		else if (cap_a_ev && (!unread_a_r || done_a))
			cap_a_r <= timer_c_count_i;
	end

	// Leaving capture mode drops a pending unread value
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			unread_a_r <= 1'b0;
		else if (cap_a_ev && (!unread_a_r || done_a))
			unread_a_r <= 1'b1;
		else if (done_a || !mode_capture)
			unread_a_r <= 1'b0;
	end

	// Byte read marks live only while a value is unread
	always_ff @(posedge clk_i)
	begin
		if (rst_i || done_a || !unread_a_r)
		begin
			read_a_lo_r <= 1'b0;
			read_a_hi_r <= 1'b0;
		end
		else
		begin
			read_a_lo_r <= read_a_lo_r || rd_a_lo;
			read_a_hi_r <= read_a_hi_r || rd_a_hi;
		end
	end

	// Capture b has no bus write path
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cap_b_r <= 16'h0000;
		else if (capture_b_event_i && (!unread_b_r || done_b))
			cap_b_r <= timer_c_count_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			unread_b_r <= 1'b0;
		else if (capture_b_event_i && (!unread_b_r || done_b))
			unread_b_r <= 1'b1;
		else if (done_b)
			unread_b_r <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || done_b || !unread_b_r)
		begin
			read_b_lo_r <= 1'b0;
			read_b_hi_r <= 1'b0;
		end
		else
		begin
			read_b_lo_r <= read_b_lo_r || rd_b_lo;
			read_b_hi_r <= read_b_hi_r || rd_b_hi;
		end
	end

	// --------------------------------------------------
	// Interrupts
	// --------------------------------------------------
	assign irq_events = {tick_c,
		capture_b_event_i && unread_b_r && !done_b,
		cap_a_ev && unread_a_r && !done_a,
		capture_b_event_i,
		cap_a_ev};

	// Write one to clear; a same cycle event still lands
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_status_r <= IRQ_RESET;
		else if (wr && hit(idx, IDX_IRQ_STATUS))
			irq_status_r <= (irq_status_r & ~dat_i[4:0]) | irq_events;
		else
			irq_status_r <= irq_status_r | irq_events;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_mask_r <= IRQ_RESET;
		else if (wr && hit(idx, IDX_IRQ_MASK))
			irq_mask_r <= dat_i[4:0];
	end

	// Registered so the level comes straight from a flop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_status_r & irq_mask_r);
	end

	// --------------------------------------------------
	// Timer and pin control outputs
	// --------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timer_a_count_en_o <= 1'b0;
			timer_b_count_en_o <= 1'b0;
			timer_ab_16_en_o <= 1'b0;
		end
		else
		begin
			// When cascaded, timer a run alone gates the 16-bit counter; timer b run stays separate
			timer_a_count_en_o <= !cascade_sixteen_select_i
				&& ctrl_r[BIT_TIMER_A_RUN];
			timer_ab_16_en_o <= cascade_sixteen_select_i
				&& ctrl_r[BIT_TIMER_A_RUN];
			timer_b_count_en_o <= ctrl_r[BIT_TIMER_B_RUN];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timer_c_count_en_o <= 1'b0;
			timer_c_interrupt_flag_o <= 1'b0;
		end
		else
		begin
			timer_c_count_en_o <= ctrl_r[BIT_TIMER_C_RUN];
			timer_c_interrupt_flag_o <= tick_c;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			period_valid_o <= 1'b0;
			period_o <= 16'h0000;
		end
		else
		begin
			period_valid_o <= !mode_capture;
			period_o <= cap_a_r;
		end
	end

	// Direction bit one means input, so enable is its inverse
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pwm_a_pin_oe_o <= 1'b0;
			pwm_b_pin_oe_o <= 1'b0;
		end
		else
		begin
			pwm_a_pin_oe_o <= ctrl_r[BIT_PWM_A_EN]
				|| !port_b_direction_r[BIT_DIR_A];
			pwm_b_pin_oe_o <= ctrl_r[BIT_PWM_B_EN]
				|| !port_b_direction_r[BIT_DIR_B];
		end
	end

	// Low duty bits are not honoured on an external time base
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pwm_full_resolution_o <= 1'b1;
		else
			pwm_full_resolution_o <= !ext_clock_select_i;
	end
endmodule

// ===== timer_capture_pwm_control_pkg.sv
// Package for the timer, capture and pwm control block.
// Assumes a classic Wishbone slave with 32-bit data, one word a register.
// Behaviour
// - Second capture unread overwrite sets bit 7
// - Second capture keeps oldest unread value
// - No capture load until both bytes read
// - First capture overflow at bit 6, same
// - PWM b enable overrides direction bit 3
// - PWM a enable overrides direction bit 2
// - Mode one: shared pair is capture a
// - Mode zero: shared pair is period
// - Cascaded: timer a run gates 16-bit counter
// - Not cascaded: timer a run gates 8-bit
// - External clock limits PWM to 8 bits
// - Internal clock supports full ten-bit resolution
// - Timer c stopped: no increment, no flag
package timer_capture_pwm_control_pkg;
	// --------------------------------------------------
	// Register indices, byte address is four times index
	// --------------------------------------------------
	localparam logic [7:0] IDX_CONTROL = 8'h17;
	localparam logic [7:0] IDX_CAP_A_LOW = 8'h20;
	localparam logic [7:0] IDX_CAP_A_HIGH = 8'h21;
	localparam logic [7:0] IDX_CAP_B_LOW = 8'h22;
	localparam logic [7:0] IDX_CAP_B_HIGH = 8'h23;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h24;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h25;
	localparam logic [7:0] IDX_PORT_B_DIR = 8'h26;
	localparam logic [7:0] IDX_STATUS = 8'h27;
	// --------------------------------------------------
	// Control fields
	// --------------------------------------------------
	localparam int BIT_TIMER_A_RUN = 0;
	localparam int BIT_TIMER_B_RUN = 1;
	localparam int BIT_TIMER_C_RUN = 2;
	localparam int BIT_CAP_OR_PERIOD = 3;
	localparam int BIT_PWM_A_EN = 4;
	localparam int BIT_PWM_B_EN = 5;
	localparam int BIT_CAP_A_OVF = 6;
	localparam int BIT_CAP_B_OVF = 7;
	localparam int BIT_DIR_A = 2;
	localparam int BIT_DIR_B = 3;
	// Interrupt status bits
	localparam int IRQ_CAP_A = 0;
	localparam int IRQ_CAP_B = 1;
	localparam int IRQ_OVF_A = 2;
	localparam int IRQ_OVF_B = 3;
	localparam int IRQ_TIMER_C = 4;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [4:0] IRQ_RESET = 5'h00;
endpackage

// ===== timer_capture_pwm_control_asserts.sv
// Assertion checker for the timer, capture and pwm control block.
// Assumes a bind to the top module, one clock and a sync reset.
`timescale 1ns/1ps
module tcpc_checker
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic timer_c_tick_i,
	input wire logic ext_clock_select_i,
	input wire logic cascade_sixteen_select_i,
	input wire logic timer_a_count_en_o,
	input wire logic timer_b_count_en_o,
	input wire logic timer_ab_16_en_o,
	input wire logic timer_c_count_en_o,
	input wire logic timer_c_interrupt_flag_o,
	input wire logic period_valid_o,
	input wire logic pwm_b_pin_oe_o,
	input wire logic pwm_full_resolution_o
);
	default clocking dflt @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----------
	// Assertions
	// ----------
	ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not answered");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack_o |-> $past(stb_i))
		else $error("ack without request");
	flag_gate_a: assert property (timer_c_interrupt_flag_o
		== ($past(timer_c_tick_i) && timer_c_count_en_o))
		else $error("timer c flag not gated by run");
	res_limit_a: assert property (!$past(rst_i) |->
		pwm_full_resolution_o == !$past(ext_clock_select_i))
		else $error("resolution does not follow clock source");
	cascade_join_a: assert property (timer_ab_16_en_o |-> $past(cascade_sixteen_select_i))
		else $error("joined counter runs uncascaded");
	cascade_split_a: assert property (timer_a_count_en_o |->
		!$past(cascade_sixteen_select_i))
		else $error("8-bit timer runs cascaded");
	// Mode, timer b and c run and pwm b pin outputs move only after a bus write
	ctrl_hold_a: assert property (!$past(rst_i, 2) &&
		$changed({timer_b_count_en_o, timer_c_count_en_o, period_valid_o, pwm_b_pin_oe_o})
		|-> $past(ack_o) || $past(ack_o, 2))
		else $error("control output changed without write");
	cover property (timer_c_interrupt_flag_o);
	cover property (timer_ab_16_en_o && pwm_b_pin_oe_o);
	cover property (!period_valid_o && !pwm_full_resolution_o);
endmodule

// ===== testbench.sv
// Self-checking bench for the timer, capture and pwm control block.
// Assumes the package and the checker are compiled first.
`timescale 1ns/1ps
module testbench import timer_capture_pwm_control_pkg::*;;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, capture_a_event_i, capture_b_event_i;
	logic timer_c_tick_i, ext_clock_select_i, cascade_sixteen_select_i, ack_o, irq_o;
	logic [9:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	logic [15:0] timer_c_count_i, period_o;
	logic timer_a_count_en_o, timer_b_count_en_o, timer_ab_16_en_o, timer_c_count_en_o;
	logic timer_c_interrupt_flag_o, period_valid_o, pwm_a_pin_oe_o, pwm_b_pin_oe_o;
	logic pwm_full_resolution_o;
	logic [7:0] q;
	int err_count, check_count;
	timer_capture_pwm_control u_timer_capture_pwm_control (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.irq_o(irq_o), .capture_a_event_i(capture_a_event_i),
		.capture_b_event_i(capture_b_event_i), .timer_c_tick_i(timer_c_tick_i),
		.timer_c_count_i(timer_c_count_i), .ext_clock_select_i(ext_clock_select_i),
		.cascade_sixteen_select_i(cascade_sixteen_select_i),
		.timer_a_count_en_o(timer_a_count_en_o), .timer_b_count_en_o(timer_b_count_en_o),
		.timer_ab_16_en_o(timer_ab_16_en_o), .timer_c_count_en_o(timer_c_count_en_o),
		.timer_c_interrupt_flag_o(timer_c_interrupt_flag_o),
		.period_valid_o(period_valid_o), .period_o(period_o),
		.pwm_a_pin_oe_o(pwm_a_pin_oe_o), .pwm_b_pin_oe_o(pwm_b_pin_oe_o),
		.pwm_full_resolution_o(pwm_full_resolution_o));
	initial
	begin
		clk_i = 1'h0;
		forever #50 clk_i = ~clk_i;
	end
	// -----
	// Tasks
	// -----
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected at %0t: got %h, want %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= {i, 2'h0};
		dat_i <= {24'h000000, d};
		do
			@(posedge clk_i);
		while (ack_o !== 1'h1);
		q = dat_o[7:0];
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic ev(input int ch, input logic [15:0] v);
		capture_a_event_i <= (ch == 0);
		capture_b_event_i <= (ch == 1);
		timer_c_tick_i <= (ch == 2);
		timer_c_count_i <= v;
		@(posedge clk_i);
		{capture_a_event_i, capture_b_event_i, timer_c_tick_i} <= 3'h0;
		@(posedge clk_i);
	endtask
	function automatic logic [7:0] outs(logic [7:0] v, logic [7:0] d, logic c, logic x);
		return {!c & v[0], v[1], c & v[0], v[2], !v[3], v[4] | !d[2], v[5] | !d[3], !x};
	endfunction
	// Two captures, a partial read, a third capture that must not land
	task automatic cap(input int ch);
		logic [15:0] a;
		logic [7:0] lo;
		logic [7:0] base;
		a = $urandom;
		base = IDX_CAP_A_LOW + 8'(2 * ch);
		ev(ch, a);
		ev(ch, ~a);
		bus(0, IDX_CONTROL, 0);
		chk(q[6 + ch], 1);
		bus(0, base, 0);
		lo = q;
		ev(ch, 16'h1234);
		bus(0, base + 8'h01, 0);
		chk({q, lo}, a);
		bus(0, IDX_CONTROL, 0);
		chk(q[6 + ch], 0);
		ev(ch, ~a);
		bus(0, base, 0);
		lo = q;
		bus(0, base + 8'h01, 0);
		chk({q, lo}, ~a);
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// --------
	// Sequence
	// --------
	initial
	begin
		{cyc_i, stb_i, we_i, capture_a_event_i, capture_b_event_i, timer_c_tick_i} = 6'h00;
		{ext_clock_select_i, cascade_sixteen_select_i, adr_i, dat_i} = '0;
		sel_i = 4'hF;
		timer_c_count_i = 16'h0000;
		rst_i = 1'h1;
		err_count = 0;
		check_count = 0;
		void'($urandom(32'hC1CC));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		bus(0, IDX_CONTROL, 0);
		chk(q, CONTROL_RESET);
		for (int k = 0; k < 8; k++)
		begin
			logic [7:0] v;
			logic [7:0] d;
			v = (k == 0) ? 8'hFF : 8'($urandom);
			d = $urandom;
			if (k[0])
				v[BIT_TIMER_B_RUN] = 1'b1;
			cascade_sixteen_select_i <= k[0];
			ext_clock_select_i <= k[1];
			bus(1, IDX_PORT_B_DIR, d);
			bus(1, IDX_CONTROL, v);
			bus(0, IDX_CONTROL, 0);
			chk(q, {2'h0, v[5:0]});
			chk({timer_a_count_en_o, timer_b_count_en_o, timer_ab_16_en_o, timer_c_count_en_o,
				period_valid_o, pwm_a_pin_oe_o, pwm_b_pin_oe_o, pwm_full_resolution_o},
				outs(v, d, k[0], k[1]));
		end
		bus(1, 8'h3F, 8'hA5);
		bus(0, 8'h3F, 0);
		chk(q, 0);
		bus(1, IDX_CONTROL, 8'h00);
		bus(1, IDX_CAP_A_LOW, 8'h5A);
		bus(1, IDX_CAP_A_HIGH, 8'hC3);
		chk(period_o, 16'hC35A);
		$display("done control");
		bus(1, IDX_CONTROL, 8'h08);
		cap(0);
		cap(1);
		$display("done capture");
		bus(1, IDX_IRQ_STATUS, 8'h1F);
		bus(1, IDX_IRQ_MASK, 8'h10);
		ev(2, 0);
		chk(timer_c_interrupt_flag_o, 0);
		bus(0, IDX_IRQ_STATUS, 0);
		chk({irq_o, q}, 0);
		bus(1, IDX_CONTROL, 8'h04);
		ev(2, 0);
		chk(timer_c_interrupt_flag_o, 1);
		bus(0, IDX_IRQ_STATUS, 0);
		chk({irq_o, q}, 9'h110);
		bus(1, IDX_IRQ_MASK, 8'h00);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 0);
		bus(1, IDX_IRQ_STATUS, 8'h10);
		bus(0, IDX_IRQ_STATUS, 0);
		chk(q, 0);
		$display("done interrupts");
		finish_test();
	end
	initial
	begin
		#(100 * 20000);
		err_count++;
		finish_test();
	end
endmodule
bind timer_capture_pwm_control tcpc_checker u_tcpc_checker (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.timer_c_tick_i(timer_c_tick_i), .ext_clock_select_i(ext_clock_select_i),
	.cascade_sixteen_select_i(cascade_sixteen_select_i),
	.timer_a_count_en_o(timer_a_count_en_o), .timer_b_count_en_o(timer_b_count_en_o),
	.timer_ab_16_en_o(timer_ab_16_en_o), .timer_c_count_en_o(timer_c_count_en_o),
	.timer_c_interrupt_flag_o(timer_c_interrupt_flag_o), .period_valid_o(period_valid_o),
	.pwm_b_pin_oe_o(pwm_b_pin_oe_o), .pwm_full_resolution_o(pwm_full_resolution_o));
